// ==== shared/timer_pkg.sv ====
// constants for the reloadable timer: register map, control fields, modes, reset values
package timer_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 2;
	localparam int CNT_W = 16;
	localparam int PRE_W = 7;

	// register indices on the plain register port
	localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
	localparam logic [ADDR_W-1:0] REG_COUNT = 2'h1;
	localparam logic [ADDR_W-1:0] REG_RELOAD = 2'h2;
	localparam logic [ADDR_W-1:0] REG_STATUS = 2'h3;

	// control register field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_OEN_BIT = 5;
	localparam int CTRL_PS_LSB = 8;

	// status register field positions
	localparam int STAT_EN_BIT = 0;
	localparam int STAT_ARMED_RUN_BIT = 1;
	localparam int STAT_OUT_BIT = 2;

	// mode field codes
	localparam logic [2:0] MODE_ONESHOT = 3'h0;
	localparam logic [2:0] MODE_TRIG = 3'h1;
	localparam logic [2:0] MODE_CONT = 3'h2;
	localparam logic [2:0] MODE_PINCNT = 3'h3;
	localparam logic [2:0] MODE_CMPCNT = 3'h4;

	// values after reset and after a reload
	localparam logic [CNT_W-1:0] CNT_RESTART = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0001;
	localparam logic [CNT_W-1:0] RLD_RESET = 16'h0000;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] PS_RESET = 3'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;
endpackage : timer_pkg

// ==== logic/timer_counting.sv ====
// reloadable 16-bit up-counter with one-shot, triggered, continuous and event-counter modes
// Notes on behaviour
// - one-shot: at reload interrupt, restart, self-disable
// - one-shot counts prescaled system clocks only
// - one-shot output inverts for one clock
// - one-shot time equals (reload-start+1) times prescale
// - triggered mode waits for polarity-selected input edge
// - triggered: count, pulse, interrupt, restart at one
// - polarity bit sets triggered pulse polarity
// - triggers ignored while counting; idle afterwards
// - triggered mode holds count until trigger edge
// - continuous: interrupt, restart at one, keep running
// - continuous output toggles each reload from polarity
// - written start count affects first pass only
// - continuous period equals reload times prescale
// - pin counter counts selected edges, no prescaler
// - comparator counter counts selected comparator edges
// - counter modes: interrupt, restart, continue, toggle output
// - polarity bit sets edge and first output level
// - prescaler divides by one up to 128
// - count rolls FFFF to 0000; reload 0 longest
// - reload below count: wrap, then reach reload
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module timer_counting #(
	parameter int COUNT_W = 16
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [timer_pkg::ADDR_W-1:0] addr,
	input wire logic [timer_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [timer_pkg::DATA_W-1:0] rdata,
	input wire logic timer_in,
	input wire logic comp_in,
	output logic timer_out,
	output logic timer_out_en,
	output logic irq
);
	import timer_pkg::*;

	if (COUNT_W < 2 || COUNT_W > DATA_W) begin : g_bad_width
		$error("COUNT_W must lie between 2 and the data width");
	end

	typedef enum logic [1:0] {
		TRG_IDLE = 2'b01,
		TRG_RUN = 2'b10
	} trg_t;

	typedef struct packed {
		logic en;
		logic [2:0] mode;
		logic pol;
		logic oen;
		logic [2:0] ps;
		logic [COUNT_W-1:0] cnt;
		logic [COUNT_W-1:0] rld;
		logic [PRE_W-1:0] pre;
		logic [2:0] pin_s;
		logic [2:0] cmp_s;
		trg_t trg;
		logic out;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic [2:0] sel_s;
	logic edge_ev;
	logic clk_mode;
	logic tick;
	logic reload_ev;
	logic toggle_mode;

	// terminal prescaler count for a divide-by-2^ps
	function automatic logic [PRE_W-1:0] presc_limit(input logic [2:0] ps);
		logic [PRE_W:0] f;
		f = (PRE_W+1)'(1) << ps;
		return PRE_W'(f - (PRE_W+1)'(1));
	endfunction : presc_limit

	always_comb begin
		s_d = s_q;
		s_d.irq = 1'b0;
		tick = 1'b0;
		// bit 0 feeds only bit 1; bit 2 holds the previous settled sample
		s_d.pin_s = {s_q.pin_s[1:0], timer_in};
		s_d.cmp_s = {s_q.cmp_s[1:0], comp_in};
		sel_s = (s_q.mode == MODE_CMPCNT) ? s_q.cmp_s : s_q.pin_s;
		// polarity 0 picks rising edges, 1 falling; inputs assumed below mclk/4
		edge_ev = s_q.pol ? (sel_s[2] & ~sel_s[1]) : (sel_s[1] & ~sel_s[2]);
		clk_mode = (s_q.mode == MODE_ONESHOT) || (s_q.mode == MODE_TRIG)
			|| (s_q.mode == MODE_CONT);
		// spare codes 5-7 count pin edges, so they toggle like the counters
		toggle_mode = (s_q.mode != MODE_ONESHOT) && (s_q.mode != MODE_TRIG);

		if (s_q.en) begin
			if (clk_mode) begin
				if (s_q.mode != MODE_TRIG || s_q.trg == TRG_RUN) begin
					if (s_q.pre == presc_limit(s_q.ps)) begin
						tick = 1'b1;
						s_d.pre = '0;
					end else begin
						s_d.pre = s_q.pre + PRE_W'(1);
					end
				end
			end else begin
				tick = edge_ev;
			end
		end

		// a trigger only arms an idle timer; later edges fall through unused
		if (s_q.en && s_q.mode == MODE_TRIG && s_q.trg == TRG_IDLE && edge_ev) begin
			s_d.trg = TRG_RUN;
			s_d.pre = '0;
		end

		reload_ev = tick && (s_q.cnt == s_q.rld);
		if (tick) begin
			// plain increment wraps ffff to 0000, so reload 0 is the longest pass
			s_d.cnt = reload_ev ? COUNT_W'(CNT_RESTART) : s_q.cnt + COUNT_W'(1);
		end

		if (reload_ev) begin
			s_d.irq = 1'b1;
			if (s_q.mode == MODE_ONESHOT) begin
				s_d.en = 1'b0;
			end
			if (s_q.mode == MODE_TRIG) begin
				s_d.trg = TRG_IDLE;
			end
		end

		if (!s_q.en) begin
			s_d.out = s_q.pol;
			s_d.trg = TRG_IDLE;
			s_d.pre = '0;
		end else if (toggle_mode) begin
			s_d.out = reload_ev ? ~s_q.out : s_q.out;
		end else if (reload_ev) begin
			s_d.out = ~s_q.pol;
		end else if (s_q.irq) begin
			// pulse over: back to the polarity level
			s_d.out = s_q.pol;
		end else begin
			// level held while counting, so a polarity flip after start shows when the time-out pulse ends
			s_d.out = s_q.out;
		end

		// software writes win over the same-cycle hardware update
		if (wr_en) begin
			unique case (addr)
				REG_CTRL: begin
					s_d.en = wdata[CTRL_EN_BIT];
					s_d.mode = wdata[CTRL_MODE_LSB +: 3];
					s_d.pol = wdata[CTRL_POL_BIT];
					s_d.oen = wdata[CTRL_OEN_BIT];
					s_d.ps = wdata[CTRL_PS_LSB +: 3];
				end
				REG_COUNT: s_d.cnt = wdata[COUNT_W-1:0];
				REG_RELOAD: s_d.rld = wdata[COUNT_W-1:0];
				REG_STATUS: begin
				end
			endcase
		end

		s_d.rdata = '0;
		if (rd_en) begin
			unique case (addr)
				REG_CTRL: begin
					s_d.rdata[CTRL_EN_BIT] = s_q.en;
					s_d.rdata[CTRL_MODE_LSB +: 3] = s_q.mode;
					s_d.rdata[CTRL_POL_BIT] = s_q.pol;
					s_d.rdata[CTRL_OEN_BIT] = s_q.oen;
					s_d.rdata[CTRL_PS_LSB +: 3] = s_q.ps;
				end
				REG_COUNT: s_d.rdata = DATA_W'(s_q.cnt);
				REG_RELOAD: s_d.rdata = DATA_W'(s_q.rld);
				REG_STATUS: begin
					s_d.rdata[STAT_EN_BIT] = s_q.en;
					s_d.rdata[STAT_ARMED_RUN_BIT] = (s_q.trg == TRG_RUN);
					s_d.rdata[STAT_OUT_BIT] = s_q.out;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q.en <= 1'b0;
			s_q.mode <= MODE_RESET;
			s_q.pol <= 1'b0;
			s_q.oen <= 1'b0;
			s_q.ps <= PS_RESET;
			s_q.cnt <= COUNT_W'(CNT_RESET);
			s_q.rld <= COUNT_W'(RLD_RESET);
			s_q.pre <= '0;
			s_q.pin_s <= 3'h0;
			s_q.cmp_s <= 3'h0;
			s_q.trg <= TRG_IDLE;
			s_q.out <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.rdata <= RDATA_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign timer_out = s_q.out;
	assign timer_out_en = s_q.oen;
	assign irq = s_q.irq;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	property p_oneshot_stop;
		reload_ev && s_q.mode == MODE_ONESHOT && !wr_en
		|=> !s_q.en && s_q.cnt == COUNT_W'(CNT_RESTART) && irq;
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

	property p_irq_pulse;
		irq |=> !irq || $past(reload_ev);
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not single cycle");

	property p_irq_cause;
		irq |-> $past(reload_ev);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without reload");

	property p_oneshot_pulse;
		reload_ev && s_q.mode == MODE_ONESHOT && !wr_en
		|=> timer_out == ~s_q.pol ##1 timer_out == s_q.pol;
	endproperty
	a_oneshot_pulse: assert property (p_oneshot_pulse) else $error("one-shot pulse wrong");

	property p_trig_wait;
		s_q.en && s_q.mode == MODE_TRIG && s_q.trg == TRG_IDLE && !wr_en
		|=> $stable(s_q.cnt);
	endproperty
	a_trig_wait: assert property (p_trig_wait) else $error("count moved before trigger");

	property p_trig_idle;
		reload_ev && s_q.mode == MODE_TRIG && !wr_en |=> s_q.trg == TRG_IDLE;
	endproperty
	a_trig_idle: assert property (p_trig_idle) else $error("trigger did not re-idle");

	property p_cont_toggle;
		reload_ev && s_q.mode == MODE_CONT && !wr_en
		|=> s_q.en && timer_out != $past(timer_out) && s_q.cnt == COUNT_W'(CNT_RESTART);
	endproperty
	a_cont_toggle: assert property (p_cont_toggle) else $error("continuous reload wrong");

	property p_counter_edge;
		s_q.en && !clk_mode && !edge_ev && !wr_en |=> $stable(s_q.cnt);
	endproperty
	a_counter_edge: assert property (p_counter_edge) else $error("count without edge");

	property p_rollover;
		tick && s_q.cnt == '1 && s_q.rld != '1 && !wr_en |=> s_q.cnt == '0;
	endproperty
	a_rollover: assert property (p_rollover) else $error("no roll to zero");

	property p_prescale;
		s_q.en && clk_mode && s_q.pre != presc_limit(s_q.ps) && !wr_en |=> $stable(s_q.cnt);
	endproperty
	a_prescale: assert property (p_prescale) else $error("tick off prescale");

	property p_idle_level;
		!s_q.en && !wr_en |=> timer_out == s_q.pol;
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle output not polarity");

	property p_out_hold;
		s_q.en && !toggle_mode && !reload_ev && !irq && !wr_en |=> $stable(timer_out);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("one-shot level moved early");

	property p_trig_pulse;
		reload_ev && s_q.mode == MODE_TRIG && !wr_en
		|=> timer_out == ~s_q.pol ##1 timer_out == s_q.pol;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("triggered pulse wrong");

	property p_trig_arm;
		s_q.en && s_q.mode == MODE_TRIG && s_q.trg == TRG_IDLE && edge_ev && !wr_en
		|=> s_q.trg == TRG_RUN;
	endproperty
	a_trig_arm: assert property (p_trig_arm) else $error("trigger edge missed");

	property p_trig_ignore;
		s_q.en && s_q.trg == TRG_RUN && !reload_ev && !wr_en |=> s_q.trg == TRG_RUN;
	endproperty
	a_trig_ignore: assert property (p_trig_ignore) else $error("run cut short");

	property p_cnt_reload;
		reload_ev && !clk_mode && !wr_en
		|=> s_q.en && timer_out != $past(timer_out) && s_q.cnt == COUNT_W'(CNT_RESTART);
	endproperty
	a_cnt_reload: assert property (p_cnt_reload) else $error("counter reload wrong");
endmodule : timer_counting

// ==== testbench/event_source.sv ====
// stand-in for the timer input pin and the comparator output
`timescale 1ns/1ps
module event_source (
	input wire logic mclk,
	output logic timer_in,
	output logic comp_in
);
	initial begin
		timer_in = 1'b0;
		comp_in = 1'b0;
	end
	// n high-low pulses on one line, nine clocks each
	task automatic pulse(input bit to_comp, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			if (to_comp) comp_in <= 1'b1;
			else timer_in <= 1'b1;
			repeat (4) @(posedge mclk);
			if (to_comp) comp_in <= 1'b0;
			else timer_in <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask : pulse
endmodule : event_source

// ==== testbench/testbench.sv ====
// self-checking bench for the reloadable timer
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
	import timer_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rdata, d, s, r, e;
	logic timer_in, comp_in, timer_out, timer_out_en, irq;
	int failures = 0;
	int comparisons = 0;
	int irq_cnt = 0;
	int out_hi = 0;
	int n, b, h;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (irq === 1'b1) irq_cnt++;
		if (timer_out === 1'b1) out_hi++;
	end
	timer_counting i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_in(timer_in), .comp_in(comp_in),
		.timer_out(timer_out), .timer_out_en(timer_out_en), .irq(irq));
	event_source i_src (.mclk(mclk), .timer_in(timer_in), .comp_in(comp_in));
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask : rd
	function automatic logic [15:0] ctl(logic en, logic [2:0] m, logic p, logic oe,
		logic [2:0] ps);
		return {5'h00, ps, 2'h0, oe, p, m, en};
	endfunction : ctl
	task automatic setup(logic [2:0] m, logic p, logic [2:0] ps, logic [15:0] st,
		logic [15:0] rl);
		wr(REG_CTRL, ctl(1'b0, m, p, 1'b1, ps));
		wr(REG_COUNT, st);
		wr(REG_RELOAD, rl);
		wr(REG_CTRL, ctl(1'b1, m, p, 1'b1, ps));
	endtask : setup
	task automatic wait_irq();
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (irq !== 1'b1 && n < 200);
		`CHK(irq, 1'b1)
	endtask : wait_irq
	task automatic final_report();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		#100us;
		failures++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		rd(REG_CTRL);
		`CHK(d, 16'h0000)
		rd(REG_COUNT);
		`CHK(d, CNT_RESET)
		rd(REG_RELOAD);
		`CHK(d, RLD_RESET)
		wr(REG_STATUS, 16'hffff);
		rd(REG_STATUS);
		`CHK(d, 16'h0000)
		@(posedge mclk);
		#1;
		`CHK(rdata, 16'h0000)
		$display("test reset done");
		// second pass wraps through ffff and 0000 before meeting reload
		for (int k = 0; k < 2; k++) begin
			s = k ? 16'hfffe : 16'h0001;
			r = k ? 16'h0001 : 16'h0003;
			e = 16'(r - s + 16'h0001);
			setup(MODE_ONESHOT, 1'b0, 3'h0, s, r);
			wait_irq();
			`CHK(n, int'(e))
			`CHK(timer_out, 1'b1)
			`CHK(timer_out_en, 1'b1)
			@(posedge mclk);
			#1;
			`CHK(irq, 1'b0)
			`CHK(timer_out, 1'b0)
			rd(REG_CTRL);
			`CHK(d[CTRL_EN_BIT], 1'b0)
			rd(REG_COUNT);
			`CHK(d, CNT_RESTART)
			b = irq_cnt;
			repeat (20) @(posedge mclk);
			`CHK(irq_cnt, b)
		end
		$display("test oneshot done");
		// start low, flip polarity while running: level must change only when the time-out pulse ends
		setup(MODE_ONESHOT, 1'b0, 3'h0, 16'h0001, 16'h0008);
		wr(REG_CTRL, ctl(1'b1, MODE_ONESHOT, 1'b1, 1'b1, 3'h0));
		#1;
		`CHK(timer_out, 1'b0)
		wait_irq();
		`CHK(timer_out, 1'b0)
		repeat (3) @(posedge mclk);
		#1;
		`CHK(timer_out, 1'b1)
		$display("test latch done");
		setup(MODE_CONT, 1'b1, 3'h2, 16'h0003, 16'h0005);
		wait_irq();
		`CHK(timer_out, 1'b0)
		wait_irq();
		`CHK(n, 20)
		`CHK(timer_out, 1'b1)
		wait_irq();
		`CHK(n, 20)
		wr(REG_CTRL, 16'h0000);
		$display("test continuous done");
		setup(MODE_TRIG, 1'b0, 3'h0, 16'h0001, 16'h0014);
		b = irq_cnt;
		h = out_hi;
		repeat (10) @(posedge mclk);
		rd(REG_COUNT);
		`CHK(d, 16'h0001)
		i_src.pulse(1'b0, 2);
		repeat (40) @(posedge mclk);
		`CHK(irq_cnt - b, 1)
		`CHK(out_hi - h, 1)
		wr(REG_CTRL, 16'h0000);
		$display("test triggered done");
		// prescale 8 set on purpose: event counting must ignore it
		for (int k = 0; k < 2; k++) begin
			setup(k ? MODE_CMPCNT : MODE_PINCNT, k[0], 3'h3, 16'h0001, 16'h0003);
			b = irq_cnt;
			i_src.pulse(k[0], 2);
			repeat (4) @(posedge mclk);
			rd(REG_COUNT);
			`CHK(d, 16'h0003)
			`CHK(irq_cnt, b)
			`CHK(timer_out, k[0])
			i_src.pulse(k[0], 1);
			repeat (4) @(posedge mclk);
			`CHK(irq_cnt - b, 1)
			`CHK(timer_out, ~k[0])
			rd(REG_COUNT);
			`CHK(d, CNT_RESTART)
			wr(REG_CTRL, 16'h0000);
		end
		$display("test counters done");
		final_report();
	end
endmodule : testbench
